// ### cmpc_pkg.sv
// ==========================================================
// converter mode and multipurpose pin configuration constants
package cmpc_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] CMPC_REG_OFFSET = 8'h0d;
  localparam logic [15:0] CMPC_REG_RESET = 16'h9000;
  localparam int CMPC_CFG_LSB = 9; // lowest stored bit
  localparam logic [8:0] CMPC_LOW_BITS_ZERO = 9'h000;
  localparam logic [15:0] CMPC_RDATA_ZERO = 16'h0000;

  // multipurpose pin function codes
  localparam logic [1:0] CMPC_FN_RSVD = 2'h0;
  localparam logic [1:0] CMPC_FN_EN = 2'h1;
  localparam logic [1:0] CMPC_FN_THERM = 2'h2;
  localparam logic [1:0] CMPC_FN_BATT = 2'h3;

  // converter type select codes and their register targets
  localparam logic [2:0] CMPC_CONV_MAP02 = 3'h0;
  localparam logic [2:0] CMPC_CONV_MAP04 = 3'h2;
  localparam logic [7:0] CMPC_MAP02_REG = 8'h02;
  localparam logic [7:0] CMPC_MAP04_REG = 8'h04;
  localparam logic [2:0] CMPC_MAP02_MODE_BIT = 3'h2;
  localparam logic [2:0] CMPC_MAP02_DITH_BIT = 3'h4;
  localparam logic [2:0] CMPC_MAP04_MODE_BIT = 3'h4;

  // ==========================================================
  // timing
  localparam int CMPC_CLK_HZ = 20_000_000;
  localparam int CMPC_CLK_MHZ = 20;
  localparam int CMPC_DEGLITCH_NS = 20_000;
  localparam int CMPC_DEGLITCH_CYCLES = (CMPC_DEGLITCH_NS * CMPC_CLK_MHZ + 999) / 1000;
  localparam int CMPC_UVLO_DELAY_S = 5;
  localparam int CMPC_UVLO_CYCLES = CMPC_UVLO_DELAY_S * CMPC_CLK_HZ;
  localparam int CMPC_SEC_CYCLES = CMPC_CLK_HZ;
  localparam int CMPC_SEC_PER_MIN = 60;
  localparam int CMPC_DLY1_MIN = 10;
  localparam int CMPC_DLY2_MIN = 22;
  localparam int CMPC_DLY3_MIN = 40;
  localparam int CMPC_DLY4_MIN = 80;
  localparam int CMPC_DLY5_MIN = 120;

  // ==========================================================
  // types
  typedef struct packed {
    logic switching_mode_select;
    logic dither_enable;
    logic [2:0] shutdown_delay;
    logic [1:0] multipurpose_pin_function;
  } cmpc_cfg_t;

  typedef struct packed {
    logic [7:0] reg_addr;
    logic [2:0] bit_idx;
    logic bit_val;
  } cmpc_i2c_cmd_t;

  typedef enum logic [1:0] {
    CMPC_EN_RUN = 2'h0,
    CMPC_EN_WAIT = 2'h1,
    CMPC_EN_OFF = 2'h3
  } cmpc_en_state_t;

  typedef enum logic {
    CMPC_LNK_IDLE = 1'h0,
    CMPC_LNK_BUSY = 1'h1
  } cmpc_lnk_state_t;

  localparam cmpc_cfg_t CMPC_CFG_RESET = CMPC_REG_RESET[15:CMPC_CFG_LSB];

  // shutdown delay code to seconds, undefined codes mean no delay
  function automatic logic [12:0] cmpc_delay_sec(input logic [2:0] code);
    logic [12:0] s;
    s = 13'h0000;
    case (code)
      3'h1: s = 13'(CMPC_DLY1_MIN * CMPC_SEC_PER_MIN);
      3'h2: s = 13'(CMPC_DLY2_MIN * CMPC_SEC_PER_MIN);
      3'h3: s = 13'(CMPC_DLY3_MIN * CMPC_SEC_PER_MIN);
      3'h4: s = 13'(CMPC_DLY4_MIN * CMPC_SEC_PER_MIN);
      3'h5: s = 13'(CMPC_DLY5_MIN * CMPC_SEC_PER_MIN);
      default: s = 13'h0000;
    endcase
    return s;
  endfunction : cmpc_delay_sec

endpackage : cmpc_pkg

// ### cmpc_deglitch.sv
`timescale 1ns/1ns
// ==========================================================
// two-flop synchroniser followed by a stability filter
module cmpc_deglitch
  import cmpc_pkg::*;
#(
  parameter int STABLE_CYCLES = CMPC_DEGLITCH_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // asynchronous level in, filtered level out
  input wire logic async_in,
  output logic filt_ff
);

  localparam int CW = $clog2(STABLE_CYCLES + 1);

  // refuse a filter length the counter cannot serve
  if (STABLE_CYCLES < 1) begin : g_bad_len
    $error("cmpc_deglitch: STABLE_CYCLES must be at least 1");
  end

  logic meta_ff;
  logic sync_ff;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic nxt_filt;
  wire logic differs = sync_ff ^ filt_ff;
  wire logic done = (cnt_ff == CW'(STABLE_CYCLES - 1));

  // count while the level differs, accept once it held long enough
  assign nxt_cnt = (differs && !done) ? cnt_ff + 1'b1 : '0;
  assign nxt_filt = (differs && done) ? sync_ff : filt_ff;

  // synchroniser and filter state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      cnt_ff <= '0;
      filt_ff <= 1'b0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      cnt_ff <= nxt_cnt;
      filt_ff <= nxt_filt;
    end
  end

  // a change only after the level stood steady for the full interval
  property p_filter_stable;
    @(posedge core_clk) disable iff (!rst_n)
      $changed(filt_ff) |-> $past(cnt_ff) == CW'(STABLE_CYCLES - 1) && $past(differs);
  endproperty
  a_filter_stable: assert property (p_filter_stable)
    else $error("filtered level changed before the stability interval");

endmodule : cmpc_deglitch

// ### cmpc_config.sv
`timescale 1ns/1ns
// How it works
// - mode bit 15 resets to forced PWM; zero asks for pulse-frequency mode.
// - with the 0x04-map converter, mode goes to its register 0x04 bit 4.
// - with the 0x02-map converter, mode goes to its register 0x02 bit 2.
// - dither bit 14 resets off; 0x02-map converter gets it in 0x02 bit 4.
// - other converter types never receive a dither write.
// - shutdown delay bits 13:11 reset to 010b, used only in enable mode.
// - delay codes: none, 10, 22, 40, 80, 120 minutes; 110b/111b undefined.
// - pin function bits 10:9 reset to 00b, reserved, pin ignored.
// - code 01b runs while pin high, disables after the delay once low.
// - code 10b routes the pin to the second thermistor monitor.
// - code 11b senses battery; low battery triggers capability resend.
// - comparator changes accepted only after 20 us of stability.
// - comparator ignored until undervoltage lockout clears plus 5 s.
// - converter type 000b targets 0x02 map, 010b targets 0x04 map.
module cmpc_config
  import cmpc_pkg::*;
#(
  parameter int SEC_CYCLES = CMPC_SEC_CYCLES,
  parameter int UVLO_CYCLES = CMPC_UVLO_CYCLES,
  parameter int DEGLITCH_CYCLES = CMPC_DEGLITCH_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port from the slave interface
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata_ff,
  // converter type select from the device configuration
  input wire logic [2:0] conv_type,
  // converter write requests to the master engine
  output logic i2c_wr_req_ff,
  output cmpc_i2c_cmd_t i2c_cmd_ff,
  input wire logic i2c_wr_done,
  // pins and supply status
  input wire logic mp_pin_in,
  input wire logic batt_cmp_low_in,
  input wire logic vcc_uvlo_ok,
  // block status
  output logic device_active_ff,
  output logic thermistor2_sel_ff,
  output logic batt_low_ff,
  output logic src_cap_resend_ff
);

  localparam int PW = $clog2(SEC_CYCLES + 1);
  localparam int UW = $clog2(UVLO_CYCLES + 1);

  // refuse timing counts the counters cannot serve
  if (SEC_CYCLES < 1 || UVLO_CYCLES < 1 || DEGLITCH_CYCLES < 1) begin : g_bad_timing
    $error("cmpc_config: timing counts must be at least 1");
  end

  // ==========================================================
  // configuration register
  cmpc_cfg_t cfg_ff;
  cmpc_cfg_t wr_cfg;
  wire logic reg_hit = (reg_addr == CMPC_REG_OFFSET);
  wire logic reg_wr = reg_wr_en && reg_hit;
  assign wr_cfg = reg_wdata[15:CMPC_CFG_LSB];
  wire logic mode_set = reg_wr && (wr_cfg.switching_mode_select != cfg_ff.switching_mode_select);
  wire logic dith_set = reg_wr && (wr_cfg.dither_enable != cfg_ff.dither_enable);
  wire logic [15:0] rd_word = reg_hit ? {cfg_ff, CMPC_LOW_BITS_ZERO} : CMPC_RDATA_ZERO;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // register storage and registered read data
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg_ff <= CMPC_CFG_RESET;
      reg_rdata_ff <= CMPC_RDATA_ZERO;
    end else begin
      if (reg_wr) begin
        cfg_ff <= wr_cfg;
      end
      reg_rdata_ff <= rd_word;
    end
  end

  property p_reset_value;
    @(posedge core_clk) disable iff (1'b0)
      !rst_n |=> cfg_ff == CMPC_CFG_RESET;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("configuration not at reset value after reset");

  // ==========================================================
  // converter write sequencing
  cmpc_lnk_state_t lnk_ff;
  cmpc_lnk_state_t nxt_lnk;
  cmpc_i2c_cmd_t mode_cmd;
  cmpc_i2c_cmd_t dith_cmd;
  logic mode_pend_ff;
  logic dith_pend_ff;
  wire logic is_map02 = (conv_type == CMPC_CONV_MAP02);
  wire logic is_map04 = (conv_type == CMPC_CONV_MAP04);
  wire logic idle = (lnk_ff == CMPC_LNK_IDLE);
  wire logic mode_go = idle && mode_pend_ff && (is_map02 || is_map04);
  wire logic dith_go = idle && dith_pend_ff && !mode_pend_ff && is_map02;
  wire logic launch = mode_go || dith_go;
  wire logic mode_clr = idle && mode_pend_ff;
  wire logic dith_clr = idle && dith_pend_ff && !(is_map02 && mode_pend_ff);

  // mode target by register map
  assign mode_cmd.reg_addr = is_map04 ? CMPC_MAP04_REG : CMPC_MAP02_REG;
  assign mode_cmd.bit_idx = is_map04 ? CMPC_MAP04_MODE_BIT : CMPC_MAP02_MODE_BIT;
  assign mode_cmd.bit_val = cfg_ff.switching_mode_select;
  assign dith_cmd.reg_addr = CMPC_MAP02_REG;
  assign dith_cmd.bit_idx = CMPC_MAP02_DITH_BIT;
  assign dith_cmd.bit_val = cfg_ff.dither_enable;

  assign nxt_lnk = idle ? (launch ? CMPC_LNK_BUSY : CMPC_LNK_IDLE)
                        : (i2c_wr_done ? CMPC_LNK_IDLE : CMPC_LNK_BUSY);

  // pending flags: a new change wins over the clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode_pend_ff <= 1'b0;
      dith_pend_ff <= 1'b0;
      lnk_ff <= CMPC_LNK_IDLE;
      i2c_wr_req_ff <= 1'b0;
      i2c_cmd_ff <= '0;
    end else begin
      mode_pend_ff <= mode_set || (mode_pend_ff && !mode_clr);
      dith_pend_ff <= dith_set || (dith_pend_ff && !dith_clr);
      lnk_ff <= nxt_lnk;
      i2c_wr_req_ff <= (nxt_lnk == CMPC_LNK_BUSY);
      if (launch) begin
        i2c_cmd_ff <= mode_go ? mode_cmd : dith_cmd;
      end
    end
  end

  property p_req_hold;
    i2c_wr_req_ff && !i2c_wr_done |=> i2c_wr_req_ff && $stable(i2c_cmd_ff);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("converter request dropped or changed before done");

  property p_map04_mode;
    $rose(i2c_wr_req_ff) && i2c_cmd_ff.reg_addr == CMPC_MAP04_REG |->
      i2c_cmd_ff.bit_idx == CMPC_MAP04_MODE_BIT &&
      i2c_cmd_ff.bit_val == $past(cfg_ff.switching_mode_select);
  endproperty
  a_map04_mode: assert property (p_map04_mode)
    else $error("wrong mode write to 0x04-map converter");

  property p_map02_mode;
    $rose(i2c_wr_req_ff) && i2c_cmd_ff.bit_idx == CMPC_MAP02_MODE_BIT |->
      i2c_cmd_ff.reg_addr == CMPC_MAP02_REG &&
      i2c_cmd_ff.bit_val == $past(cfg_ff.switching_mode_select);
  endproperty
  a_map02_mode: assert property (p_map02_mode)
    else $error("wrong mode write to 0x02-map converter");

  property p_map02_dith;
    $rose(i2c_wr_req_ff) && i2c_cmd_ff.reg_addr == CMPC_MAP02_REG &&
      i2c_cmd_ff.bit_idx == CMPC_MAP02_DITH_BIT |->
      $past(is_map02) && i2c_cmd_ff.bit_val == $past(cfg_ff.dither_enable);
  endproperty
  a_map02_dith: assert property (p_map02_dith)
    else $error("dither write value or target wrong");

  property p_type_gate;
    $rose(i2c_wr_req_ff) |-> $past(is_map02) || $past(is_map04);
  endproperty
  a_type_gate: assert property (p_type_gate)
    else $error("converter write issued for unsupported type");

  property p_write_pends;
    mode_set |=> mode_pend_ff;
  endproperty
  a_write_pends: assert property (p_write_pends)
    else $error("mode change did not schedule a converter write");

  // ==========================================================
  // multipurpose pin: enable with shutdown delay
  cmpc_en_state_t en_ff;
  cmpc_en_state_t nxt_en;
  logic en_pin;
  logic [PW-1:0] presc_ff;
  logic [12:0] sec_ff;
  wire logic fn_en = (cfg_ff.multipurpose_pin_function == CMPC_FN_EN);
  wire logic [12:0] dly_sec = cmpc_delay_sec(cfg_ff.shutdown_delay);
  wire logic sec_tick = (presc_ff == PW'(SEC_CYCLES - 1));
  wire logic dly_done = sec_tick && (sec_ff == dly_sec - 13'h0001);
  wire logic waiting = (en_ff == CMPC_EN_WAIT);
  wire logic [PW-1:0] nxt_presc = (waiting && !sec_tick) ? presc_ff + 1'b1 : '0;
  wire logic [12:0] nxt_sec = waiting ? (sec_tick ? sec_ff + 13'h0001 : sec_ff) : 13'h0000;

  cmpc_deglitch #(
    .STABLE_CYCLES(1)
  ) u_en_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(mp_pin_in),
    .filt_ff(en_pin)
  );

  // enable state: run, counting toward off, off
  always_comb begin
    nxt_en = en_ff;
    case (en_ff)
      CMPC_EN_RUN: begin
        if (fn_en && !en_pin) begin
          nxt_en = (dly_sec == 13'h0000) ? CMPC_EN_OFF : CMPC_EN_WAIT;
        end
      end
      CMPC_EN_WAIT: begin
        if (!fn_en || en_pin) begin
          nxt_en = CMPC_EN_RUN;
        end else if (dly_done) begin
          nxt_en = CMPC_EN_OFF;
        end
      end
      CMPC_EN_OFF: begin
        if (!fn_en || en_pin) begin
          nxt_en = CMPC_EN_RUN;
        end
      end
      default: nxt_en = CMPC_EN_RUN;
    endcase
  end

  // enable timers and active output
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      en_ff <= CMPC_EN_RUN;
      presc_ff <= '0;
      sec_ff <= 13'h0000;
      device_active_ff <= 1'b1;
    end else begin
      en_ff <= nxt_en;
      presc_ff <= nxt_presc;
      sec_ff <= nxt_sec;
      device_active_ff <= (nxt_en != CMPC_EN_OFF);
    end
  end

  property p_not_en_active;
    !fn_en |=> device_active_ff;
  endproperty
  a_not_en_active: assert property (p_not_en_active)
    else $error("device disabled while pin not in enable mode");

  property p_en_high_active;
    fn_en && en_pin |=> device_active_ff && en_ff == CMPC_EN_RUN;
  endproperty
  a_en_high_active: assert property (p_en_high_active)
    else $error("device not running with enable asserted");

  // ==========================================================
  // thermistor routing and battery sensing
  logic batt_filt;
  logic [UW-1:0] uvlo_ff;
  logic uvlo_done_ff;
  wire logic uvlo_end = (uvlo_ff == UW'(UVLO_CYCLES - 1));
  wire logic [UW-1:0] nxt_uvlo = (vcc_uvlo_ok && !uvlo_done_ff && !uvlo_end) ? uvlo_ff + 1'b1
                                                                            : '0;
  wire logic nxt_uvlo_done = vcc_uvlo_ok && (uvlo_done_ff || uvlo_end);
  wire logic fn_batt = (cfg_ff.multipurpose_pin_function == CMPC_FN_BATT);
  wire logic nxt_batt_low = uvlo_done_ff && fn_batt && batt_filt;

  cmpc_deglitch #(
    .STABLE_CYCLES(DEGLITCH_CYCLES)
  ) u_batt_filt (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(batt_cmp_low_in),
    .filt_ff(batt_filt)
  );

  // supply delay, battery state and resend pulse
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      uvlo_ff <= '0;
      uvlo_done_ff <= 1'b0;
      batt_low_ff <= 1'b0;
      src_cap_resend_ff <= 1'b0;
      thermistor2_sel_ff <= 1'b0;
    end else begin
      uvlo_ff <= nxt_uvlo;
      uvlo_done_ff <= nxt_uvlo_done;
      batt_low_ff <= nxt_batt_low;
      src_cap_resend_ff <= nxt_batt_low && !batt_low_ff;
      thermistor2_sel_ff <= (cfg_ff.multipurpose_pin_function == CMPC_FN_THERM);
    end
  end

  property p_resend_on_low;
    $rose(batt_low_ff) |-> src_cap_resend_ff ##1 !src_cap_resend_ff;
  endproperty
  a_resend_on_low: assert property (p_resend_on_low)
    else $error("capability resend pulse missing or too long");

  property p_uvlo_gate;
    !uvlo_done_ff |=> !batt_low_ff;
  endproperty
  a_uvlo_gate: assert property (p_uvlo_gate)
    else $error("battery low accepted before supply delay");

  property p_therm_route;
    cfg_ff.multipurpose_pin_function != CMPC_FN_THERM |=> !thermistor2_sel_ff;
  endproperty
  a_therm_route: assert property (p_therm_route)
    else $error("thermistor routing active in wrong pin mode");

endmodule : cmpc_config

// ### cmpc_conv_model.sv
`timescale 1ns/1ns
// ==========================================================
// step-down converter seen through the master engine
module cmpc_conv_model
  import cmpc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // bit-set request from the block
  input wire logic req,
  input wire cmpc_i2c_cmd_t cmd,
  // answer latency in cycles
  input wire logic [3:0] lat,
  output logic done
);
  logic [7:0] img02;
  logic [7:0] img04;
  int n_wr;
  int cnt;

  // count out the latency, pulse done, apply the bit to the register image
  always @(posedge core_clk) begin
    done <= 1'b0;
    if (!rst_n) begin
      cnt <= 0;
      n_wr <= 0;
      img02 <= 8'h00;
      img04 <= 8'hff; // differs from img02 so a wrong map shows
    end else if (req && !done) begin
      if (cnt >= int'(lat)) begin
        done <= 1'b1;
        cnt <= 0;
        n_wr <= n_wr + 1;
        if (cmd.reg_addr == 8'h02) begin
          img02[cmd.bit_idx] <= cmd.bit_val;
        end else if (cmd.reg_addr == 8'h04) begin
          img04[cmd.bit_idx] <= cmd.bit_val;
        end
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : cmpc_conv_model

// ### test_cmpc_config.sv
`timescale 1ns/1ns
// ==========================================================
// self-checking bench for the mode and pin configuration register
module test_cmpc_config
  import cmpc_pkg::*;
;
  localparam int SEC = 4;
  // design and model signals
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr_en = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata_ff;
  logic [2:0] conv_type = 3'h0;
  logic i2c_wr_req_ff;
  cmpc_i2c_cmd_t i2c_cmd_ff;
  logic i2c_wr_done;
  logic mp_pin_in = 1'b1;
  logic batt_cmp_low_in = 1'b0;
  logic vcc_uvlo_ok = 1'b0;
  logic device_active_ff;
  logic thermistor2_sel_ff;
  logic batt_low_ff;
  logic src_cap_resend_ff;
  logic [3:0] lat = 4'h0;
  logic [15:0] rv;
  int n_mismatch = 0;
  int checked = 0;
  int n_resend = 0;

  always #25 core_clk = ~core_clk;

  // count cycles with the resend pulse high
  always @(posedge core_clk) begin
    if (src_cap_resend_ff === 1'b1) n_resend <= n_resend + 1;
  end

  cmpc_config #(.SEC_CYCLES(SEC), .UVLO_CYCLES(10), .DEGLITCH_CYCLES(3)) u_cmpc_config (
    .core_clk(core_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .conv_type(conv_type),
    .i2c_wr_req_ff(i2c_wr_req_ff), .i2c_cmd_ff(i2c_cmd_ff), .i2c_wr_done(i2c_wr_done),
    .mp_pin_in(mp_pin_in), .batt_cmp_low_in(batt_cmp_low_in), .vcc_uvlo_ok(vcc_uvlo_ok),
    .device_active_ff(device_active_ff), .thermistor2_sel_ff(thermistor2_sel_ff),
    .batt_low_ff(batt_low_ff), .src_cap_resend_ff(src_cap_resend_ff));

  cmpc_conv_model u_cmpc_conv_model (.core_clk(core_clk), .rst_n(rst_n),
    .req(i2c_wr_req_ff), .cmd(i2c_cmd_ff), .lat(lat), .done(i2c_wr_done));

  // ==========================================================
  // shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge core_clk);
    reg_addr = a;
    @(negedge core_clk);
    d = reg_rdata_ff;
  endtask : rd

  // bounded wait for the converter write count, then a quiet span
  task automatic wait_wr(input int n);
    for (int i = 0; i < 300 && u_cmpc_conv_model.n_wr < n; i++) @(negedge core_clk);
    repeat (20) @(negedge core_clk);
    check(16'(u_cmpc_conv_model.n_wr), 16'(n));
  endtask : wait_wr

  task automatic wait_active(input logic v, input int lim, output int n);
    n = 0;
    while (device_active_ff !== v && n < lim) begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_active

  function automatic logic [15:0] cfg(input logic [2:0] c, input logic [1:0] f);
    return {2'b01, c, f, 9'h000};
  endfunction : cfg

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd(8'h0d, rv);
    check(rv, 16'h9000);
    check(16'(device_active_ff), 16'h1);
    check(16'({i2c_wr_req_ff, thermistor2_sel_ff, batt_low_ff}), 16'h0);
  endtask : t_reset

  task automatic t_regs;
    wr(8'h0c, 16'h0000);
    rd(8'h0d, rv);
    check(rv, 16'h9000);
    rd(8'h0c, rv);
    check(rv, 16'h0000);
    wr(8'h0d, 16'h91ff);
    rd(8'h0d, rv);
    check(rv, 16'h9000);
    wait_wr(0);
  endtask : t_regs

  task automatic t_map02;
    conv_type = 3'h0;
    lat = 4'h6;
    wr(8'h0d, 16'h5000);
    wait_wr(2);
    check(16'(u_cmpc_conv_model.img02), 16'h0010);
    lat = 4'h0;
    wr(8'h0d, 16'h9000);
    wait_wr(4);
    check(16'(u_cmpc_conv_model.img02), 16'h0004);
  endtask : t_map02

  task automatic t_map04;
    conv_type = 3'h2;
    wr(8'h0d, 16'h5000);
    wait_wr(5);
    check(16'(u_cmpc_conv_model.img04), 16'h00ef);
    check(16'(u_cmpc_conv_model.img02), 16'h0004);
    wr(8'h0d, 16'h9000);
    wait_wr(6);
    check(16'(u_cmpc_conv_model.img04), 16'h00ff);
    conv_type = 3'h1;
    wr(8'h0d, 16'h5000);
    wait_wr(6);
  endtask : t_map04

  task automatic t_pin_fn;
    mp_pin_in = 1'b0;
    repeat (40) @(negedge core_clk);
    check(16'(device_active_ff), 16'h1);
    wr(8'h0d, cfg(3'h0, 2'h2));
    repeat (40) @(negedge core_clk);
    check(16'(thermistor2_sel_ff), 16'h1);
    check(16'(device_active_ff), 16'h1);
    mp_pin_in = 1'b1;
  endtask : t_pin_fn

  task automatic t_enable;
    int mins[8];
    int n;
    int exp;
    mins = '{0, 10, 22, 40, 80, 120, 0, 0};
    for (int c = 0; c < 8; c++) begin
      mp_pin_in = 1'b1;
      // let the pin through its synchroniser before enable mode is chosen
      repeat (4) @(negedge core_clk);
      wr(8'h0d, cfg(3'(c), 2'h1));
      wait_active(1'b1, 20, n);
      check(16'(device_active_ff), 16'h1);
      exp = mins[c] * 60 * SEC;
      mp_pin_in = 1'b0;
      wait_active(1'b0, exp + 40, n);
      check(16'(n + 4 >= exp && n <= exp + 12), 16'h1);
    end
    mp_pin_in = 1'b1;
    wr(8'h0d, cfg(3'h1, 2'h1));
    wait_active(1'b1, 20, n);
    mp_pin_in = 1'b0;
    repeat (2000) @(negedge core_clk);
    mp_pin_in = 1'b1;
    repeat (20) @(negedge core_clk);
    mp_pin_in = 1'b0;
    repeat (2000) @(negedge core_clk);
    check(16'(device_active_ff), 16'h1);
    mp_pin_in = 1'b1;
  endtask : t_enable

  task automatic t_batt;
    wr(8'h0d, cfg(3'h2, 2'h3));
    batt_cmp_low_in = 1'b1;
    repeat (30) @(negedge core_clk);
    check(16'(batt_low_ff), 16'h0);
    vcc_uvlo_ok = 1'b1;
    repeat (6) @(negedge core_clk);
    check(16'(batt_low_ff), 16'h0);
    repeat (30) @(negedge core_clk);
    check(16'(batt_low_ff), 16'h1);
    check(16'(n_resend), 16'h1);
    batt_cmp_low_in = 1'b0;
    repeat (2) @(negedge core_clk);
    batt_cmp_low_in = 1'b1;
    repeat (20) @(negedge core_clk);
    check(16'(batt_low_ff), 16'h1);
    batt_cmp_low_in = 1'b0;
    repeat (20) @(negedge core_clk);
    check(16'(batt_low_ff), 16'h0);
    check(16'(n_resend), 16'h1);
  endtask : t_batt

  // ==========================================================
  // verdict and run control
  task automatic give_verdict;
    if (n_mismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    t_reset;
    t_regs;
    t_map02;
    t_map04;
    t_pin_fn;
    t_enable;
    t_batt;
    give_verdict;
  end

  // watchdog well past the longest expected run
  initial begin
    #(90000 * 50);
    n_mismatch++;
    give_verdict;
  end
endmodule : test_cmpc_config
